/* File: common/switch_on_fault_stage_defines.svh */
// Register map, field positions, reset values and timing of the stage
`ifndef SWITCH_ON_FAULT_STAGE_DEFINES_SVH
`define SWITCH_ON_FAULT_STAGE_DEFINES_SVH

// Register byte offsets
`define SWITCH_ON_FAULT_STAGE_OFS_CTRL       8'h00
`define SWITCH_ON_FAULT_STAGE_OFS_PICKUP     8'h04
`define SWITCH_ON_FAULT_STAGE_OFS_DEAD_DLY   8'h08
`define SWITCH_ON_FAULT_STAGE_OFS_ACT_WIN    8'h0c
`define SWITCH_ON_FAULT_STAGE_OFS_NOMINAL    8'h10
`define SWITCH_ON_FAULT_STAGE_OFS_PICKUP_PRI 8'h14
`define SWITCH_ON_FAULT_STAGE_OFS_STATUS     8'h18
`define SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT 8'h1c

// Control register fields
`define SWITCH_ON_FAULT_STAGE_CTRL_EN        0
`define SWITCH_ON_FAULT_STAGE_CTRL_SRC_MSB   2
`define SWITCH_ON_FAULT_STAGE_CTRL_SRC_LSB   1
`define SWITCH_ON_FAULT_STAGE_CTRL_SEL_MSB   6
`define SWITCH_ON_FAULT_STAGE_CTRL_SEL_LSB   4

// Status register fields
`define SWITCH_ON_FAULT_STAGE_STAT_BLOCKED   0
`define SWITCH_ON_FAULT_STAGE_STAT_START     1
`define SWITCH_ON_FAULT_STAGE_STAT_TRIP      2
`define SWITCH_ON_FAULT_STAGE_STAT_OPEN      3

// Currents are in hundredths of nominal current
`define SWITCH_ON_FAULT_STAGE_PU_SCALE       32'h0000_0064
`define SWITCH_ON_FAULT_STAGE_LOW_LIMIT      16'h0002
`define SWITCH_ON_FAULT_STAGE_RST_PICKUP     16'h0096
// Times as printed, in milliseconds
`define SWITCH_ON_FAULT_STAGE_DEAD_DLY_MS    16'h00c8
`define SWITCH_ON_FAULT_STAGE_ACT_WIN_MS     16'h03e8
// Arbitrary default primary amperes of nominal current
`define SWITCH_ON_FAULT_STAGE_RST_NOMINAL    16'h0064
`define SWITCH_ON_FAULT_STAGE_RST_EN         1'b1

// Millisecond time base at a 4 ns clock
`define SWITCH_ON_FAULT_STAGE_CLK_PERIOD_NS  4
`define SWITCH_ON_FAULT_STAGE_TICK_NS        1000000
`define SWITCH_ON_FAULT_STAGE_TICK_CYCLES    (`SWITCH_ON_FAULT_STAGE_TICK_NS / `SWITCH_ON_FAULT_STAGE_CLK_PERIOD_NS)

`endif

/* File: common/switch_on_fault_stage_pkg.sv */
// Types shared by the switch-on-to-fault stage and its bench
`include "switch_on_fault_stage_defines.svh"
package switch_on_fault_stage_pkg;

  // Stage states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_OPEN   = 5'b00010,
    ST_ARMED  = 5'b00100,
    ST_WINDOW = 5'b01000,
    ST_TRIP   = 5'b10000
  } switch_on_fault_stage_state_t;

  // Where breaker-open detection comes from
  typedef enum logic [1:0] {
    SRC_CURRENT = 2'b00,
    SRC_PHYS    = 2'b01,
    SRC_VIRT    = 2'b10
  } switch_on_fault_stage_src_t;

  // Settings written by software
  typedef struct packed {
    logic        enable;
    switch_on_fault_stage_src_t   src;
    logic [2:0]  sel;
    logic [15:0] pickup;
    logic [15:0] dead_dly;
    logic [15:0] act_win;
    logic [15:0] nominal;
  } switch_on_fault_stage_cfg_t;

  // Three phase magnitudes, hundredths of nominal current
  typedef struct packed {
    logic [2:0][15:0] mag;
  } switch_on_fault_stage_cur_t;

  localparam switch_on_fault_stage_cfg_t SWITCH_ON_FAULT_STAGE_CFG_RST = '{
    enable:   `SWITCH_ON_FAULT_STAGE_RST_EN,
    src:      SRC_CURRENT,
    sel:      3'h0,
    pickup:   `SWITCH_ON_FAULT_STAGE_RST_PICKUP,
    dead_dly: `SWITCH_ON_FAULT_STAGE_DEAD_DLY_MS,
    act_win:  `SWITCH_ON_FAULT_STAGE_ACT_WIN_MS,
    nominal:  `SWITCH_ON_FAULT_STAGE_RST_NOMINAL
  };

endpackage : switch_on_fault_stage_pkg

/* File: core/switch_on_fault_stage_stage.sv */
// Switch-on-to-fault protection stage with an APB register slave
// Summary of operation
// - Never trips without prior breaker-open detection
// - Open while largest phase below 0.02 In
// - Open may come from selected digital input
// - No input selected means current method
// - Arm after open persists for dead delay
// - Pick-up before arming gives no operation
// - Trip on pick-up within post-closure window
// - No trip once the window has expired
// - Trip asserted at once, no delay
// - Pick-up held per-unit, also shown primary
// - State shown as blocked, start or trip
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "switch_on_fault_stage_defines.svh"

module switch_on_fault_stage_stage #(
  parameter int unsigned TICK_CYCLES = `SWITCH_ON_FAULT_STAGE_TICK_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire switch_on_fault_stage_pkg::switch_on_fault_stage_cur_t phase,
  input  wire logic [7:0]        physical_input_select,
  input  wire logic [7:0]        virtual_input_select,
  output var  logic              stage_blocked,
  output var  logic              stage_start,
  output var  logic              stage_trip,
  output var  logic [15:0]       trip_count
);
  import switch_on_fault_stage_pkg::*;

  // Settings and state
  switch_on_fault_stage_cfg_t   cfg;          // Software settings
  switch_on_fault_stage_cfg_t   next_cfg;
  switch_on_fault_stage_state_t state;        // Stage sequence
  switch_on_fault_stage_state_t next_state;
  logic [15:0] tmr;          // Millisecond timer of the state
  logic [15:0] next_tmr;
  logic [31:0] tick_cnt;     // Cycle counter of the time base
  logic [31:0] next_tick_cnt;
  logic        tick;         // One-cycle millisecond strobe
  logic [7:0]  phys_meta;    // First synchroniser stage
  logic [7:0]  phys_sync;    // Second synchroniser stage

  // Bus answer values
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [15:0] next_trip_count;
  logic        next_blocked;
  logic        next_start;
  logic        next_trip;

  // Derived signals
  logic [15:0] max_cur;      // Largest phase magnitude
  logic        open_det;     // Breaker judged open
  logic        over_pu;      // Largest phase above pick-up
  logic        trip_pulse;   // Entry into trip this cycle
  logic        tmr_inc;      // Timer advances this cycle
  logic [31:0] pu_product;   // Pick-up times nominal amperes
  logic [31:0] pu_primary;   // Pick-up in primary amperes
  logic        access;       // APB access phase
  logic        bus_done;     // Transfer completes at this edge
  logic        mapped;       // Address hits a register
  logic        wr_count;     // Software clears the trip counter

  // Physical input pins are synchronised before any use; virtual inputs and phases are used directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phys_meta <= 8'h00;
      phys_sync <= 8'h00;
    end else if (ce) begin
      phys_meta <= physical_input_select;
      phys_sync <= phys_meta;
    end
  end

  // Millisecond time base
  always_comb begin
    tick = (tick_cnt == 32'(TICK_CYCLES - 1));
    if (tick) begin
      next_tick_cnt = 32'h0000_0000;
    end else begin
      next_tick_cnt = tick_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0000_0000;
    end else if (ce) begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // Largest phase and open detection
  always_comb begin
    max_cur = phase.mag[0];
    for (int i = 1; i < 3; i++) begin
      if (phase.mag[i] > max_cur) begin
        max_cur = phase.mag[i];
      end
    end
    over_pu = (max_cur > cfg.pickup);
    // Digital sources replace the current test when chosen
    case (cfg.src)
      SRC_PHYS: begin
        open_det = phys_sync[cfg.sel];
      end
      SRC_VIRT: begin
        open_det = virtual_input_select[cfg.sel];
      end
      default: begin
        // Default setting uses the low current limit
        open_det = (max_cur < `SWITCH_ON_FAULT_STAGE_LOW_LIMIT);
      end
    endcase
  end

  // Stage sequence and its timer
  always_comb begin
    next_state = state;
    next_tmr   = tmr;
    trip_pulse = 1'b0;
    // Timer saturates so a long open period never wraps
    tmr_inc    = tick && (tmr != 16'hffff);
    if (!cfg.enable) begin
      // Disabled stage falls back to blocked
      next_state = ST_IDLE;
      next_tmr   = 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          // Nothing happens until the breaker is seen open
          if (open_det) begin
            next_state = ST_OPEN;
            next_tmr   = 16'h0000;
          end
        end
        ST_OPEN: begin
          if (!open_det) begin
            // Closed too early: no arming, fault ignored
            next_state = ST_IDLE;
            next_tmr   = 16'h0000;
          end else if (tmr >= cfg.dead_dly) begin
            next_state = ST_ARMED;
            next_tmr   = 16'h0000;
          end else if (tmr_inc) begin
            next_tmr = tmr + 16'h0001;
          end
        end
        ST_ARMED: begin
          if (!open_det) begin
            next_tmr = 16'h0000;
            if (over_pu) begin
              // Closed straight onto a fault
              next_state = ST_TRIP;
              trip_pulse = 1'b1;
            end else begin
              next_state = ST_WINDOW;
            end
          end
        end
        ST_WINDOW: begin
          // Expiry checked first so a late fault never trips
          if (tmr >= cfg.act_win) begin
            next_state = ST_IDLE;
            next_tmr   = 16'h0000;
          end else if (over_pu) begin
            next_state = ST_TRIP;
            trip_pulse = 1'b1;
          end else if (open_det) begin
            // Breaker reopened: a new dead period begins
            next_state = ST_OPEN;
            next_tmr   = 16'h0000;
          end else if (tmr_inc) begin
            next_tmr = tmr + 16'h0001;
          end
        end
        ST_TRIP: begin
          // Trip holds while the fault current persists
          if (!over_pu) begin
            next_state = open_det ? ST_OPEN : ST_IDLE;
            next_tmr   = 16'h0000;
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_tmr   = 16'h0000;
        end
      endcase
    end
    // Exactly one of the three status outputs is high
    next_blocked = (next_state == ST_IDLE) ||
                   (next_state == ST_OPEN);
    next_start   = (next_state == ST_ARMED) ||
                   (next_state == ST_WINDOW);
    next_trip    = (next_state == ST_TRIP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= ST_IDLE;
      tmr           <= 16'h0000;
      stage_blocked <= 1'b1;
      stage_start   <= 1'b0;
      stage_trip    <= 1'b0;
    end else if (ce) begin
      state         <= next_state;
      tmr           <= next_tmr;
      stage_blocked <= next_blocked;
      stage_start   <= next_start;
      stage_trip    <= next_trip;
    end
  end

  // Pick-up in primary amperes, read path only
  always_comb begin
    pu_product = {16'h0000, cfg.pickup} * {16'h0000, cfg.nominal};
    pu_primary = pu_product / `SWITCH_ON_FAULT_STAGE_PU_SCALE;
  end

  // APB slave: one wait state, then the answer
  always_comb begin
    access       = psel && penable;
    bus_done     = access && pready;
    next_cfg     = cfg;
    next_prdata  = prdata;
    next_pready  = access && !pready;
    next_pslverr = 1'b0;
    wr_count     = 1'b0;
    mapped       = 1'b1;
    // Address decode and read mux
    if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_CTRL) begin
      next_prdata = 32'h0000_0000;
      next_prdata[`SWITCH_ON_FAULT_STAGE_CTRL_EN] = cfg.enable;
      next_prdata[`SWITCH_ON_FAULT_STAGE_CTRL_SRC_MSB:`SWITCH_ON_FAULT_STAGE_CTRL_SRC_LSB] = cfg.src;
      next_prdata[`SWITCH_ON_FAULT_STAGE_CTRL_SEL_MSB:`SWITCH_ON_FAULT_STAGE_CTRL_SEL_LSB] = cfg.sel;
    end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_PICKUP) begin
      next_prdata = {16'h0000, cfg.pickup};
    end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_DEAD_DLY) begin
      next_prdata = {16'h0000, cfg.dead_dly};
    end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_ACT_WIN) begin
      next_prdata = {16'h0000, cfg.act_win};
    end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_NOMINAL) begin
      next_prdata = {16'h0000, cfg.nominal};
    end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_PICKUP_PRI) begin
      next_prdata = pu_primary;
    end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_STATUS) begin
      next_prdata = 32'h0000_0000;
      next_prdata[`SWITCH_ON_FAULT_STAGE_STAT_BLOCKED] = stage_blocked;
      next_prdata[`SWITCH_ON_FAULT_STAGE_STAT_START]   = stage_start;
      next_prdata[`SWITCH_ON_FAULT_STAGE_STAT_TRIP]    = stage_trip;
      next_prdata[`SWITCH_ON_FAULT_STAGE_STAT_OPEN]    = open_det;
    end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT) begin
      next_prdata = {16'h0000, trip_count};
    end else begin
      // Unmapped: reads zero and flags an error
      mapped      = 1'b0;
      next_prdata = 32'h0000_0000;
    end
    // Read data and error are loaded only for the answer cycle
    if (!(access && !pready)) begin
      next_prdata = prdata;
    end
    next_pslverr = access && !pready && !mapped;
    // Writes take effect at the completing edge only
    if (bus_done && pwrite && mapped) begin
      if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_CTRL) begin
        next_cfg.enable = pwdata[`SWITCH_ON_FAULT_STAGE_CTRL_EN];
        next_cfg.src    = switch_on_fault_stage_src_t'(
          pwdata[`SWITCH_ON_FAULT_STAGE_CTRL_SRC_MSB:`SWITCH_ON_FAULT_STAGE_CTRL_SRC_LSB]);
        next_cfg.sel    =
          pwdata[`SWITCH_ON_FAULT_STAGE_CTRL_SEL_MSB:`SWITCH_ON_FAULT_STAGE_CTRL_SEL_LSB];
      end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_PICKUP) begin
        next_cfg.pickup = pwdata[15:0];
      end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_DEAD_DLY) begin
        next_cfg.dead_dly = pwdata[15:0];
      end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_ACT_WIN) begin
        next_cfg.act_win = pwdata[15:0];
      end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_NOMINAL) begin
        next_cfg.nominal = pwdata[15:0];
      end else if (paddr == `SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT) begin
        // Any write clears the counter
        wr_count = 1'b1;
      end
    end
    // A trip in the clearing cycle still counts: set wins
    next_trip_count = wr_count ? 16'h0000 : trip_count;
    if (trip_pulse) begin
      next_trip_count = next_trip_count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg        <= SWITCH_ON_FAULT_STAGE_CFG_RST;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      trip_count <= 16'h0000;
    end else if (ce) begin
      cfg        <= next_cfg;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      trip_count <= next_trip_count;
    end
  end

endmodule : switch_on_fault_stage_stage
`default_nettype wire

/* File: test/switch_on_fault_stage_feed.sv */
// Model of the phase measurement and breaker inputs
`timescale 1ns/100ps
`default_nettype none
module switch_on_fault_stage_feed (
  input  wire logic [15:0]       level,    // Largest phase magnitude
  input  wire logic [15:0]       other,    // Smaller phases, not above
  input  wire logic [1:0]        lead,     // Phase carrying the largest
  input  wire logic              brk_open, // Breaker contacts open
  input  wire logic [2:0]        sel,      // Input that reports it
  output var  switch_on_fault_stage_pkg::switch_on_fault_stage_cur_t phase,
  output var  logic [7:0]        physical_input_select,
  output var  logic [7:0]        virtual_input_select
);
  import switch_on_fault_stage_pkg::*;
  // Rotate the largest phase so no single phase is trusted
  always_comb begin
    phase.mag = {other, other, other};
    phase.mag[lead] = level;
  end
  // Unselected inputs show the opposite, so a wrong index shows
  always_comb begin
    physical_input_select = brk_open ? (8'h1 << sel) : ~(8'h1 << sel);
    virtual_input_select = physical_input_select;
  end
endmodule : switch_on_fault_stage_feed
`default_nettype wire

/* File: test/switch_on_fault_stage_stage_test.sv */
// Self-checking bench of the switch-on-to-fault stage
`timescale 1ns/100ps
`default_nettype none
`include "switch_on_fault_stage_defines.svh"
module switch_on_fault_stage_stage_test;
  import switch_on_fault_stage_pkg::*;
  localparam int TICK = 4;   // Cycles per ms tick, shortened
  localparam int PU   = 180; // Pick-up in hundredths of nominal
  localparam int DEAD = 3;   // Dead-line delay in ms
  localparam int WIN  = 6;   // Window after closure in ms
  // Open level, open ms, closing level, wait ms, fault level
  typedef struct { int ctrl, lo, op, cl, wt, hi; } switch_on_fault_stage_case_t;
  switch_on_fault_stage_case_t  cases [12] = '{'{1,0,6,200,0,200}, '{1,0,1,200,0,200},
    '{1,0,6,50,2,200}, '{1,0,6,50,10,200}, '{1,2,6,200,0,200},
    '{1,1,6,200,0,200}, '{1,0,6,180,2,180}, '{0,0,6,200,0,200},
    '{8'h53,100,6,200,0,200}, '{8'h25,100,6,50,2,200},
    '{7,100,6,200,0,200}, '{1,0,6,50,1,181}};
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, phys, virt;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        err, blocked, start, trip, brk_open;
  logic [15:0] trip_count, level, other;
  logic [1:0]  lead;
  logic [2:0]  sel;
  switch_on_fault_stage_cur_t   phase;
  logic [31:0] regm [8]; // Register model
  int          fails, check_count, trips;
  switch_on_fault_stage_stage #(.TICK_CYCLES(TICK)) dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase(phase), .physical_input_select(phys),
    .virtual_input_select(virt), .stage_blocked(blocked),
    .stage_start(start), .stage_trip(trip), .trip_count(trip_count));
  switch_on_fault_stage_feed feed (.level(level), .other(other), .lead(lead),
    .brk_open(brk_open), .sel(sel), .phase(phase),
    .physical_input_select(phys), .virtual_input_select(virt));
  // Free-running 4 ns clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected trip from the settings of one case
  function automatic logic model(input switch_on_fault_stage_case_t c);
    logic dig;
    dig = c.ctrl[2:1] == 2'b01 || c.ctrl[2:1] == 2'b10;
    if (!c.ctrl[0] || !(dig || c.lo < 2) || c.op <= DEAD + 1) begin
      return 1'b0;
    end
    return c.hi > PU && (c.cl > PU || c.wt < WIN - 1);
  endfunction : model
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for ready, held until its sampling edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Values read here are those sampled at this rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: bus timeout", $time);
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a < `SWITCH_ON_FAULT_STAGE_OFS_PICKUP_PRI || a == `SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT) begin
      regm[a[4:2]] = a == `SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT ? 32'h0 : d;
    end
    regm[5] = regm[1] * regm[4] / 100;
  endtask : wr
  task automatic rdc(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd, a <= `SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT ? regm[a[4:2]] : 32'h0);
    chk({31'h0, err}, {31'h0, a > `SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT});
  endtask : rdc
  // Hold one current level and breaker position for n cycles
  task automatic drive(input int lv, input logic op, input int n);
    seed = lfsr(seed);
    level <= lv[15:0];
    other <= lv[15:0] & seed[15:0];
    lead <= seed[17:16] == 2'h3 ? 2'h0 : seed[17:16];
    brk_open <= op;
    repeat (n) @(posedge pclk);
  endtask : drive
  task automatic run_case(input switch_on_fault_stage_case_t c);
    logic exp;
    exp = model(c);
    wr(`SWITCH_ON_FAULT_STAGE_OFS_CTRL, c.ctrl);
    sel <= c.ctrl[6:4];
    drive(c.lo, 1'b1, c.op * TICK);
    drive(c.cl, 1'b0, c.wt * TICK + 4);
    drive(c.hi, 1'b0, 1);
    @(negedge pclk);
    chk({31'h0, trip}, {31'h0, exp});
    trips += exp;
    chk({16'h0, trip_count}, trips);
    // Inputs move only on a rising edge
    @(posedge pclk);
    drive(50, 1'b0, (WIN + 2) * TICK);
    @(negedge pclk);
    chk({31'h0, blocked}, 32'h1);
  endtask : run_case
  initial begin
    {seed, fails, check_count, trips} = {32'h278969fe, 96'h0};
    {presetn, ce, psel, penable, pwrite, paddr, pwdata} = {2'b01, 43'h0};
    {level, other, lead, brk_open, sel} = {16'h32, 22'h0};
    regm = '{32'h1, 32'h96, 32'hc8, 32'h3e8, 32'h64, 32'h96, 32'h1, 32'h0};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdc(8'(i * 4));
    end
    wr(`SWITCH_ON_FAULT_STAGE_OFS_PICKUP_PRI, 32'h7);
    wr(`SWITCH_ON_FAULT_STAGE_OFS_DEAD_DLY, DEAD);
    wr(`SWITCH_ON_FAULT_STAGE_OFS_ACT_WIN, WIN);
    wr(`SWITCH_ON_FAULT_STAGE_OFS_NOMINAL, 32'hfa);
    wr(`SWITCH_ON_FAULT_STAGE_OFS_PICKUP, PU);
    rdc(`SWITCH_ON_FAULT_STAGE_OFS_PICKUP_PRI);
    $display("register test done");
    foreach (cases[i]) begin
      run_case(cases[i]);
      $display("case %0d done", i);
    end
    // Clock enable low: an open breaker must not move the stage
    @(posedge pclk);
    ce <= 1'b0;
    drive(0, 1'b1, 40);
    @(negedge pclk);
    chk({30'h0, start, blocked}, 32'h1);
    chk({16'h0, trip_count}, trips);
    @(posedge pclk);
    ce <= 1'b1;
    drive(50, 1'b0, 4);
    $display("freeze test done");
    regm[7] = trips;
    rdc(`SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT);
    wr(`SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT, 32'h0);
    rdc(`SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT);
    rdc(`SWITCH_ON_FAULT_STAGE_OFS_STATUS);
    $display("counter test done");
    complete_run();
  end
endmodule : switch_on_fault_stage_stage_test
`default_nettype wire

/* File: test/switch_on_fault_stage_sva.sv */
// Port checker of the switch-on-to-fault stage
`timescale 1ns/100ps
`default_nettype none
`include "switch_on_fault_stage_defines.svh"
module switch_on_fault_stage_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        stage_blocked,
  input wire logic        stage_start,
  input wire logic        stage_trip,
  input wire logic [15:0] trip_count
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic next_cleared; // Counter clear lands at this edge
  logic cleared;      // Counter clear landed at the last edge
  // Track clears so the hold check knows when the count may jump
  always_comb next_cleared = psel && penable && pready && pwrite && ce
                             && paddr == `SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cleared <= 1'b0;
    end else begin
      cleared <= next_cleared;
    end
  end
  // First access cycle of a transfer
  sequence access_s;
    psel && penable && !pready && ce;
  endsequence
  // Completing write to the trip counter
  sequence clear_s;
    next_cleared;
  endsequence
  // Entry into trip
  sequence trip_entry_s;
    $rose(stage_trip);
  endsequence
  state_onehot_a:
    assert property ($onehot({stage_blocked, stage_start, stage_trip}))
    else $error("status outputs not one-hot");
  trip_armed_a:
    assert property (trip_entry_s |-> $past(stage_start))
    else $error("trip without armed stage");
  arm_after_open_a:
    assert property ($rose(stage_start) |-> $past(stage_blocked, 8))
    else $error("armed without open period");
  trip_count_a:
    assert property (trip_entry_s |-> trip_count == $past(trip_count)
                     + 16'h1 || trip_count == 16'h1)
    else $error("trip counter did not step");
  count_hold_a:
    assert property (!$rose(stage_trip) && !cleared |-> $stable(trip_count))
    else $error("trip counter moved alone");
  counter_clear_a:
    assert property (clear_s |=> trip_count == 16'h0 || $rose(stage_trip))
    else $error("trip counter not cleared");
  trip_release_a:
    assert property ($fell(stage_trip) |-> stage_blocked)
    else $error("trip not followed by blocked");
  ready_pulse_a:
    assert property (pready && ce |=> !pready)
    else $error("ready longer than one cycle");
  ready_time_a:
    assert property (access_s ##1 ce |-> pready)
    else $error("ready late");
  unmapped_a:
    assert property (pready && paddr > `SWITCH_ON_FAULT_STAGE_OFS_TRIP_COUNT
                     |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : switch_on_fault_stage_sva
bind switch_on_fault_stage_stage switch_on_fault_stage_sva chk (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stage_blocked(stage_blocked), .stage_start(stage_start),
  .stage_trip(stage_trip), .trip_count(trip_count));
`default_nettype wire
